// ==== verilog/cfg_regs_pkg.sv ====
// constants for the configuration command/status register block
// Notes on behaviour
// - identification word bits 31..16 show the device identifier loaded from EEPROM, read-only
// - identification word bits 15..0 show the vendor identifier loaded from EEPROM, writes ignored
// - EEPROM-sourced fields reload automatically each time PCI reset is released
// - scratch register bits 15..8 are writable and read back the last write
// - signature register returns a hard-wired constant and ignores writes
// - parity error detected flag sets on any parity error, enable or not; resets 0
// - system error signalled flag sets whenever the device drives the system error pin
// - master abort received flag sets when own master transaction ends in master abort
// - target abort received flag sets when a target aborts own master transaction
// - device select timing field always reads binary 01, medium timing
// - master parity reported sets only on parity error pin, acting master, response enabled
// - fast back-to-back capable bit is constant 1, read-only
// - capabilities bit is read-only and mirrors bit 19 of control/status register 18
// - with system error response enabled, address parity error drives system error pin
// - with parity response disabled (reset value), parity errors drive neither the parity error pin nor system error bit 13 of register 5
// - with parity response enabled, parity error sets system error bit 13 of register 5
// - bus master enable gates all master activity, resets 0; host should set it
// - memory space enable allows memory accesses when 1, blocks when 0, resets 0
// - I/O space control is inverted: 0 permits I/O accesses, 1 blocks; resets 0
// - registers take defaults on hardware reset and keep contents across software reset
package cfg_regs_pkg;
	localparam logic [7:0] OFS_IDENTITY = 8'h00;
	localparam logic [7:0] OFS_CMD_STATUS = 8'h04;
	localparam logic [7:0] OFS_SCRATCH = 8'h40;
	localparam logic [7:0] OFS_SIGNATURE = 8'h80;
	// arbitrary value, not tied to any maker
	localparam logic [31:0] SIGNATURE_VALUE = 32'h5A5A_C3C3;
	localparam int BIT_PARITY_DETECTED = 31;
	localparam int BIT_SERR_SIGNALLED = 30;
	localparam int BIT_MASTER_ABORT = 29;
	localparam int BIT_TARGET_ABORT = 28;
	localparam int BIT_DEVSEL_LO = 25;
	localparam int BIT_MASTER_PARITY = 24;
	localparam int BIT_FAST_B2B = 23;
	localparam int BIT_CAP_LIST = 20;
	localparam int BIT_SERR_ENABLE = 8;
	localparam int BIT_PARITY_ENABLE = 6;
	localparam int BIT_MASTER_ENABLE = 2;
	localparam int BIT_MEMORY_ENABLE = 1;
	localparam int BIT_IO_DISABLE = 0;
	localparam int SCRATCH_LO = 8;
	localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
	localparam logic FAST_B2B_VALUE = 1'h1;
	localparam logic [7:0] SCRATCH_RESET = 8'h00;
	localparam logic [15:0] ID_RESET = 16'h0000;
	localparam int NUM_FLAGS = 5;
	localparam int FLAG_POS [NUM_FLAGS] = '{31, 30, 29, 28, 24};
endpackage

// ==== verilog/sticky_flag.sv ====
// one sticky status bit: hardware sets, host clears by writing one
`timescale 1ns/1ns
module sticky_flag (
	input wire logic clk,
	input wire logic rst,
	input wire logic set_pulse,
	input wire logic clear_pulse,
	output logic flag
);
	always_ff @(posedge clk) begin
		if (rst) begin
			flag <= 1'b0;
		end else if (set_pulse) begin
			// set beats a clear in the same cycle
			flag <= 1'b1;
		end else if (clear_pulse) begin
			flag <= 1'b0;
		end
	end

	chk_set_wins_clear: assert property (@(posedge clk) disable iff (rst)
		set_pulse |=> flag)
		else $error("event lost against clear");
	chk_flag_holds_set: assert property (@(posedge clk) disable iff (rst)
		(flag && !clear_pulse) |=> flag)
		else $error("flag dropped without clear");
endmodule // sticky_flag

// ==== verilog/id_loader.sv ====
// requests the EEPROM identifier load after each reset release and holds the result
`timescale 1ns/1ns
module id_loader (
	input wire logic clk,
	input wire logic rst,
	input wire logic eeprom_done,
	input wire logic [15:0] eeprom_device_id,
	input wire logic [15:0] eeprom_vendor_id,
	output logic load_request,
	output logic ids_valid,
	output logic [15:0] device_id,
	output logic [15:0] vendor_id
);
	typedef enum logic [2:0] {
		LD_START = 3'h1,
		LD_WAIT = 3'h2,
		LD_DONE = 3'h4
	} load_state_e;
	load_state_e state_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= LD_START;
		end else begin
			case (state_reg)
				LD_START: state_reg <= LD_WAIT;
				LD_WAIT: if (eeprom_done) state_reg <= LD_DONE;
				LD_DONE: state_reg <= LD_DONE;
				default: state_reg <= LD_START;
			endcase
		end
	end

	assign load_request = (state_reg == LD_START) && !rst;
	assign ids_valid = (state_reg == LD_DONE);

	always_ff @(posedge clk) begin
		if (rst) begin
			device_id <= cfg_regs_pkg::ID_RESET;
			vendor_id <= cfg_regs_pkg::ID_RESET;
		end else if (state_reg == LD_WAIT && eeprom_done) begin
			device_id <= eeprom_device_id;
			vendor_id <= eeprom_vendor_id;
		end
	end

	chk_load_after_reset: assert property (@(posedge clk)
		$fell(rst) |-> load_request)
		else $error("no load request after reset release");
	chk_ids_captured: assert property (@(posedge clk) disable iff (rst)
		(state_reg == LD_WAIT && eeprom_done) |=> (device_id == $past(eeprom_device_id)
		&& vendor_id == $past(eeprom_vendor_id)))
		else $error("identifiers not captured");
	cov_load_done: cover property (@(posedge clk) disable iff (rst) $rose(ids_valid));
endmodule // id_loader

// ==== verilog/pci_config_command_status_regs.sv ====
// configuration identity, command/status, scratch and signature registers
`timescale 1ns/1ns
module pci_config_command_status_regs (
	input wire logic clk,
	input wire logic rst,
	// configuration access from the PCI target
	input wire logic cfg_write,
	input wire logic cfg_read,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_byte_en,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	// serial EEPROM loader handshake
	input wire logic eeprom_done,
	input wire logic [15:0] eeprom_device_id,
	input wire logic [15:0] eeprom_vendor_id,
	output logic eeprom_load_request,
	// bus events from the PCI core
	input wire logic data_parity_error,
	input wire logic addr_parity_error,
	input wire logic perr_seen,
	input wire logic acting_master,
	input wire logic master_abort_event,
	input wire logic target_abort_event,
	input wire logic control_status_reg_18_bit19,
	// access gating
	input wire logic master_request,
	input wire logic memory_hit,
	input wire logic io_hit,
	output logic master_grant_ok,
	output logic memory_claim,
	output logic io_claim,
	// open-drain error pins
	output logic serr_out,
	output logic serr_oe,
	output logic perr_out,
	output logic perr_oe,
	output logic control_status_reg_5_sys_err_set
);
	logic system_error_response_enable;
	logic parity_response_enable;
	logic bus_master_enable;
	logic memory_space_enable;
	logic io_space_disable;
	logic [7:0] scratch_reg;
	logic ids_valid;
	logic [15:0] loaded_device_identifier;
	logic [15:0] loaded_vendor_identifier;
	logic serr_drive_reg;
	logic perr_drive_reg;
	logic sys_err_set_reg;
	logic [31:0] rdata_reg;
	logic rvalid_reg;
	logic [31:0] read_word;
	logic [cfg_regs_pkg::NUM_FLAGS-1:0] flag_set;
	logic [cfg_regs_pkg::NUM_FLAGS-1:0] flag_q;
	logic write_cmd_status;
	logic write_scratch;
	logic parity_error_detected_flag;
	logic system_error_signalled_flag;
	logic master_abort_received_flag;
	logic target_abort_received_flag;
	logic master_parity_reported_flag;
	logic [1:0] devsel_timing_field;
	logic fast_b2b_capable_flag;
	logic capability_list_flag;

	assign write_cmd_status = cfg_write && (cfg_addr == cfg_regs_pkg::OFS_CMD_STATUS);
	assign write_scratch = cfg_write && (cfg_addr == cfg_regs_pkg::OFS_SCRATCH);

	// identifiers come back from EEPROM after every reset release
	id_loader u_id_loader (
		.clk(clk),
		.rst(rst),
		.eeprom_done(eeprom_done),
		.eeprom_device_id(eeprom_device_id),
		.eeprom_vendor_id(eeprom_vendor_id),
		.load_request(eeprom_load_request),
		.ids_valid(ids_valid),
		.device_id(loaded_device_identifier),
		.vendor_id(loaded_vendor_identifier)
	);

	// command bits, byte lane 0 and lane 1
	// only the hardware reset clears these; a software reset of the
	// controller core does not reach this block at all
	always_ff @(posedge clk) begin
		if (rst) begin
			parity_response_enable <= 1'b0;
			bus_master_enable <= 1'b0;
			memory_space_enable <= 1'b0;
			io_space_disable <= 1'b0;
		end else if (write_cmd_status && cfg_byte_en[0]) begin
			parity_response_enable <= cfg_wdata[cfg_regs_pkg::BIT_PARITY_ENABLE];
			bus_master_enable <= cfg_wdata[cfg_regs_pkg::BIT_MASTER_ENABLE];
			memory_space_enable <= cfg_wdata[cfg_regs_pkg::BIT_MEMORY_ENABLE];
			io_space_disable <= cfg_wdata[cfg_regs_pkg::BIT_IO_DISABLE];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			system_error_response_enable <= 1'b0;
		end else if (write_cmd_status && cfg_byte_en[1]) begin
			system_error_response_enable <= cfg_wdata[cfg_regs_pkg::BIT_SERR_ENABLE];
		end
	end

	// scratch byte sits in lane 1
	always_ff @(posedge clk) begin
		if (rst) begin
			scratch_reg <= cfg_regs_pkg::SCRATCH_RESET;
		end else if (write_scratch && cfg_byte_en[1]) begin
			scratch_reg <= cfg_wdata[cfg_regs_pkg::SCRATCH_LO +: 8];
		end
	end

	// error pin drivers, one-cycle pulses
	always_ff @(posedge clk) begin
		if (rst) begin
			serr_drive_reg <= 1'b0;
			perr_drive_reg <= 1'b0;
			sys_err_set_reg <= 1'b0;
		end else begin
			serr_drive_reg <= system_error_response_enable && addr_parity_error;
			// parity response off: a data parity error is counted in status only
			perr_drive_reg <= parity_response_enable && data_parity_error;
			sys_err_set_reg <= parity_response_enable && (data_parity_error || addr_parity_error);
		end
	end

	assign serr_out = 1'b0;
	assign serr_oe = serr_drive_reg;
	assign perr_out = 1'b0;
	assign perr_oe = perr_drive_reg;
	assign control_status_reg_5_sys_err_set = sys_err_set_reg;

	// flag order follows FLAG_POS: parity, serr, master abort, target abort, master parity
	assign flag_set[0] = data_parity_error || addr_parity_error;
	assign flag_set[1] = serr_drive_reg;
	assign flag_set[2] = acting_master && master_abort_event;
	assign flag_set[3] = acting_master && target_abort_event;
	assign flag_set[4] = (perr_drive_reg || perr_seen) && acting_master && parity_response_enable;

	// status flags clear by writing one to the bit in lane 3
	generate
		for (genvar i = 0; i < cfg_regs_pkg::NUM_FLAGS; i++) begin : g_flag
			sticky_flag u_flag (
				.clk(clk),
				.rst(rst),
				.set_pulse(flag_set[i]),
				.clear_pulse(write_cmd_status && cfg_byte_en[3] && cfg_wdata[cfg_regs_pkg::FLAG_POS[i]]),
				.flag(flag_q[i])
			);
		end
	endgenerate

	assign parity_error_detected_flag = flag_q[0];
	assign system_error_signalled_flag = flag_q[1];
	assign master_abort_received_flag = flag_q[2];
	assign target_abort_received_flag = flag_q[3];
	assign master_parity_reported_flag = flag_q[4];
	assign devsel_timing_field = cfg_regs_pkg::DEVSEL_MEDIUM;
	assign fast_b2b_capable_flag = cfg_regs_pkg::FAST_B2B_VALUE;
	assign capability_list_flag = control_status_reg_18_bit19;

	// access gating toward the PCI core
	assign master_grant_ok = master_request && bus_master_enable;
	assign memory_claim = memory_hit && memory_space_enable;
	assign io_claim = io_hit && !io_space_disable;

	// read mux; unmapped offsets read zero
	always_comb begin
		read_word = 32'h0000_0000;
		case (cfg_addr)
			cfg_regs_pkg::OFS_IDENTITY: begin
				read_word = {loaded_device_identifier, loaded_vendor_identifier};
			end
			cfg_regs_pkg::OFS_CMD_STATUS: begin
				read_word[cfg_regs_pkg::BIT_PARITY_DETECTED] = parity_error_detected_flag;
				read_word[cfg_regs_pkg::BIT_SERR_SIGNALLED] = system_error_signalled_flag;
				read_word[cfg_regs_pkg::BIT_MASTER_ABORT] = master_abort_received_flag;
				read_word[cfg_regs_pkg::BIT_TARGET_ABORT] = target_abort_received_flag;
				read_word[cfg_regs_pkg::BIT_DEVSEL_LO +: 2] = devsel_timing_field;
				read_word[cfg_regs_pkg::BIT_MASTER_PARITY] = master_parity_reported_flag;
				read_word[cfg_regs_pkg::BIT_FAST_B2B] = fast_b2b_capable_flag;
				read_word[cfg_regs_pkg::BIT_CAP_LIST] = capability_list_flag;
				read_word[cfg_regs_pkg::BIT_SERR_ENABLE] = system_error_response_enable;
				read_word[cfg_regs_pkg::BIT_PARITY_ENABLE] = parity_response_enable;
				read_word[cfg_regs_pkg::BIT_MASTER_ENABLE] = bus_master_enable;
				read_word[cfg_regs_pkg::BIT_MEMORY_ENABLE] = memory_space_enable;
				read_word[cfg_regs_pkg::BIT_IO_DISABLE] = io_space_disable;
			end
			cfg_regs_pkg::OFS_SCRATCH: begin
				read_word[cfg_regs_pkg::SCRATCH_LO +: 8] = scratch_reg;
			end
			cfg_regs_pkg::OFS_SIGNATURE: begin
				read_word = cfg_regs_pkg::SIGNATURE_VALUE;
			end
			default: begin
				read_word = 32'h0000_0000;
			end
		endcase
	end

	// whole word returned; byte enables only matter for writes
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= cfg_read;
			if (cfg_read) begin
				rdata_reg <= read_word;
			end
		end
	end

	assign cfg_rdata = rdata_reg;
	assign cfg_rvalid = rvalid_reg;

	chk_id_read_only: assert property (@(posedge clk) disable iff (rst)
		(ids_valid && !$rose(ids_valid)) |-> $stable(loaded_device_identifier))
		else $error("device identifier changed after load");
	chk_vendor_read_only: assert property (@(posedge clk) disable iff (rst)
		(ids_valid && !$rose(ids_valid)) |-> $stable(loaded_vendor_identifier))
		else $error("vendor identifier changed after load");
	chk_scratch_readback: assert property (@(posedge clk) disable iff (rst)
		(write_scratch && cfg_byte_en[1]) ##1 (cfg_read && cfg_addr == cfg_regs_pkg::OFS_SCRATCH
		&& !write_scratch) |=> cfg_rdata[15:8] == $past(cfg_wdata[15:8], 2))
		else $error("scratch byte did not read back");
	chk_signature_const: assert property (@(posedge clk) disable iff (rst)
		(cfg_read && cfg_addr == cfg_regs_pkg::OFS_SIGNATURE) |=> cfg_rvalid
		&& cfg_rdata == cfg_regs_pkg::SIGNATURE_VALUE)
		else $error("signature read wrong");
	chk_parity_any_enable: assert property (@(posedge clk) disable iff (rst)
		(data_parity_error || addr_parity_error) |=> parity_error_detected_flag)
		else $error("parity flag not set");
	chk_serr_sets_ses: assert property (@(posedge clk) disable iff (rst)
		serr_oe |=> system_error_signalled_flag)
		else $error("serr driven without status");
	chk_master_abort: assert property (@(posedge clk) disable iff (rst)
		(acting_master && master_abort_event) |=> master_abort_received_flag)
		else $error("master abort not recorded");
	chk_target_abort: assert property (@(posedge clk) disable iff (rst)
		(acting_master && target_abort_event) |=> target_abort_received_flag)
		else $error("target abort not recorded");
	chk_devsel_read: assert property (@(posedge clk) disable iff (rst)
		(cfg_read && cfg_addr == cfg_regs_pkg::OFS_CMD_STATUS) |=> cfg_rdata[26:25] == 2'h1
		&& cfg_rdata[23])
		else $error("devsel or fast b2b field wrong");
	chk_mpr_needs_enable: assert property (@(posedge clk) disable iff (rst)
		$rose(master_parity_reported_flag) |-> $past(parity_response_enable && acting_master))
		else $error("master parity set without conditions");
	chk_cap_mirror: assert property (@(posedge clk) disable iff (rst)
		(cfg_read && cfg_addr == cfg_regs_pkg::OFS_CMD_STATUS) |=>
		cfg_rdata[20] == $past(control_status_reg_18_bit19))
		else $error("capability bit not mirrored");
	chk_serr_on_addr: assert property (@(posedge clk) disable iff (rst)
		(system_error_response_enable && addr_parity_error) |=> serr_oe)
		else $error("serr not driven");
	chk_no_perr_disabled: assert property (@(posedge clk) disable iff (rst)
		!$past(parity_response_enable) |-> !perr_oe && !control_status_reg_5_sys_err_set)
		else $error("parity response while disabled");
	chk_control_status_reg_5_set: assert property (@(posedge clk) disable iff (rst)
		(parity_response_enable && data_parity_error) |=> control_status_reg_5_sys_err_set)
		else $error("control_status_reg_5 system error not set");
	chk_master_gate: assert property (@(posedge clk) disable iff (rst)
		!bus_master_enable |-> !master_grant_ok)
		else $error("master activity while disabled");
	chk_mem_io_gate: assert property (@(posedge clk) disable iff (rst)
		(!memory_space_enable |-> !memory_claim) and (io_space_disable |-> !io_claim))
		else $error("access claimed while blocked");
	chk_reset_defaults: assert property (@(posedge clk)
		rst |=> !bus_master_enable && !memory_space_enable && !io_space_disable
		&& !parity_response_enable && !system_error_response_enable)
		else $error("command bits not at default");
	chk_flags_reset: assert property (@(posedge clk)
		rst |=> flag_q == '0)
		else $error("status flags not cleared by reset");
	chk_addr_parity_control_status_reg_5: assert property (@(posedge clk) disable iff (rst)
		(parity_response_enable && addr_parity_error) |=> control_status_reg_5_sys_err_set)
		else $error("control_status_reg_5 system error missed on address parity");
	chk_mpr_sets: assert property (@(posedge clk) disable iff (rst)
		(perr_seen && acting_master && parity_response_enable) |=> master_parity_reported_flag)
		else $error("master parity report not set");
	chk_abort_needs_master: assert property (@(posedge clk) disable iff (rst)
		($rose(master_abort_received_flag) || $rose(target_abort_received_flag)) |-> $past(acting_master))
		else $error("abort recorded while not master");
	chk_io_open: assert property (@(posedge clk) disable iff (rst)
		(io_hit && !io_space_disable) |-> io_claim)
		else $error("io access blocked while permitted");
	chk_memory_open: assert property (@(posedge clk) disable iff (rst)
		(memory_hit && memory_space_enable) |-> memory_claim)
		else $error("memory access blocked while permitted");
	chk_scratch_lane_off: assert property (@(posedge clk) disable iff (rst)
		(write_scratch && !cfg_byte_en[1]) |=> $stable(scratch_reg))
		else $error("scratch changed without its lane");
	// only a lane 0 write or hardware reset may move the lane 0 command bits
	chk_cmd_bits_hold: assert property (@(posedge clk) disable iff (rst)
		!(write_cmd_status && cfg_byte_en[0]) |=> $stable({parity_response_enable, bus_master_enable,
		memory_space_enable, io_space_disable}))
		else $error("command bits changed without a write");

	cov_parity_reported: cover property (@(posedge clk) disable iff (rst) $rose(master_parity_reported_flag));
	cov_serr_driven: cover property (@(posedge clk) disable iff (rst) $rose(serr_oe));
	cov_flag_cleared: cover property (@(posedge clk) disable iff (rst) $fell(parity_error_detected_flag));
	cov_master_enabled: cover property (@(posedge clk) disable iff (rst) master_grant_ok);
endmodule // pci_config_command_status_regs

// ==== testbench/eeprom_loader_model.sv ====
// behavioural serial EEPROM loader that answers each identifier load request
`timescale 1ns/1ns
module eeprom_loader_model #(
	parameter int LOAD_DELAY = 6,
	// arbitrary identifier values, not tied to any maker
	parameter logic [15:0] DEVICE_BASE = 16'h1234,
	parameter logic [15:0] VENDOR_VALUE = 16'h5678
) (
	input wire logic clk,
	input wire logic load_request,
	output logic done,
	output logic [15:0] device_id,
	output logic [15:0] vendor_id
);
	int countdown = 0;
	logic [15:0] loads = 16'h0000;
	initial begin
		done = 1'b0;
		device_id = 16'h0000;
		vendor_id = 16'h0000;
	end
	// ids only valid with done; otherwise inverted so a stale capture shows up
	always @(posedge clk) begin
		done <= 1'b0;
		device_id <= ~(DEVICE_BASE + loads);
		vendor_id <= ~VENDOR_VALUE;
		if (load_request) begin
			countdown <= LOAD_DELAY;
		end else if (countdown == 1) begin
			countdown <= 0;
			done <= 1'b1;
			device_id <= DEVICE_BASE + loads;
			vendor_id <= VENDOR_VALUE;
			loads <= loads + 16'h0001;
		end else if (countdown > 1) begin
			countdown <= countdown - 1;
		end
	end
endmodule // eeprom_loader_model

// ==== testbench/tb_top.sv ====
// self-checking testbench for the configuration command/status register block
`timescale 1ns/1ns
module tb_top;
	localparam logic [15:0] DEV0 = 16'h1234;
	localparam logic [15:0] VEN0 = 16'h5678;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_write = 1'b0;
	logic cfg_read = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [3:0] cfg_byte_en = 4'h0;
	logic [31:0] cfg_wdata = 32'h0000_0000;
	logic [31:0] cfg_rdata;
	logic cfg_rvalid;
	logic eeprom_done;
	logic [15:0] eeprom_device_id;
	logic [15:0] eeprom_vendor_id;
	logic eeprom_load_request;
	// data parity, address parity, perr seen, acting master, master abort, target abort
	logic [5:0] ev = 6'h00;
	logic cap_bit = 1'b1;
	logic [2:0] req = 3'h0;
	logic [2:0] claim;
	logic serr_out;
	logic serr_oe;
	logic perr_out;
	logic perr_oe;
	logic control_status_reg_5_set;
	int fails = 0;
	int checked = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	pci_config_command_status_regs u_pci_config_command_status_regs (
		.clk(clk), .rst(rst), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr),
		.cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.eeprom_done(eeprom_done), .eeprom_device_id(eeprom_device_id), .eeprom_vendor_id(eeprom_vendor_id),
		.eeprom_load_request(eeprom_load_request), .data_parity_error(ev[0]), .addr_parity_error(ev[1]),
		.perr_seen(ev[2]), .acting_master(ev[3]), .master_abort_event(ev[4]), .target_abort_event(ev[5]),
		.control_status_reg_18_bit19(cap_bit), .master_request(req[2]), .memory_hit(req[1]), .io_hit(req[0]),
		.master_grant_ok(claim[2]), .memory_claim(claim[1]), .io_claim(claim[0]), .serr_out(serr_out),
		.serr_oe(serr_oe), .perr_out(perr_out), .perr_oe(perr_oe), .control_status_reg_5_sys_err_set(control_status_reg_5_set)
	);
	eeprom_loader_model #(.LOAD_DELAY(6), .DEVICE_BASE(DEV0), .VENDOR_VALUE(VEN0)) u_eeprom_loader_model (
		.clk(clk), .load_request(eeprom_load_request), .done(eeprom_done),
		.device_id(eeprom_device_id), .vendor_id(eeprom_vendor_id)
	);
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// the whole run is a little over a hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			finish_test();
		end
	end
	task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic compare_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] config_command_status(input logic [31:0] low);
		config_command_status = low | (32'(cfg_regs_pkg::DEVSEL_MEDIUM) << cfg_regs_pkg::BIT_DEVSEL_LO)
			| (32'(cfg_regs_pkg::FAST_B2B_VALUE) << cfg_regs_pkg::BIT_FAST_B2B)
			| (32'(cap_bit) << cfg_regs_pkg::BIT_CAP_LIST);
	endfunction
	task automatic reset_dut;
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		cfg_write <= 1'b1;
		cfg_addr <= a;
		cfg_byte_en <= be;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_write <= 1'b0;
	endtask
	task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		cfg_read <= 1'b1;
		cfg_addr <= a;
		@(posedge clk);
		cfg_read <= 1'b0;
		#1;
		compare_bit(cfg_rvalid, 1'b1);
		compare_word(cfg_rdata, exp);
	endtask
	task automatic gate_chk(input logic [2:0] exp);
		@(posedge clk);
		req <= 3'b111;
		#1;
		compare_word({29'h0, claim}, {29'h0, exp});
		@(posedge clk);
		req <= 3'b000;
	endtask
	task automatic ev_pulse(input logic [5:0] bits);
		@(posedge clk);
		ev <= bits;
		@(posedge clk);
		ev <= 6'h00;
		#1;
	endtask
	initial begin
		reset_dut();
		cfg_rd(8'h00, 32'h0000_0000);
		repeat (10) @(posedge clk);
		cfg_rd(8'h00, {DEV0, VEN0});
		cfg_rd(8'h04, config_command_status(32'h0000_0000));
		cfg_rd(8'h80, cfg_regs_pkg::SIGNATURE_VALUE);
		cfg_rd(8'h08, 32'h0000_0000);
		gate_chk(3'b001);
		$display("test reset values done");
		cfg_wr(8'h00, 4'hF, 32'hFFFF_FFFF);
		cfg_wr(8'h80, 4'hF, 32'h0000_0000);
		cfg_rd(8'h00, {DEV0, VEN0});
		cfg_rd(8'h80, cfg_regs_pkg::SIGNATURE_VALUE);
		cfg_wr(8'h04, 4'h3, 32'hFFFF_FFFF);
		cfg_rd(8'h04, config_command_status(32'h0000_0147));
		gate_chk(3'b110);
		cap_bit <= 1'b0;
		@(posedge clk);
		cfg_rd(8'h04, config_command_status(32'h0000_0147));
		cap_bit <= 1'b1;
		cfg_wr(8'h40, 4'hF, 32'hFFFF_FFFF);
		cfg_rd(8'h40, 32'h0000_FF00);
		cfg_wr(8'h40, 4'h2, 32'h0000_A500);
		cfg_wr(8'h40, 4'h1, 32'h0000_1234);
		cfg_rd(8'h40, 32'h0000_A500);
		// read in the cycle right after the write must see the new byte
		@(posedge clk);
		cfg_write <= 1'b1;
		cfg_addr <= 8'h40;
		cfg_byte_en <= 4'h2;
		cfg_wdata <= 32'h0000_5A00;
		@(posedge clk);
		cfg_write <= 1'b0;
		cfg_read <= 1'b1;
		@(posedge clk);
		cfg_read <= 1'b0;
		#1;
		compare_bit(cfg_rvalid, 1'b1);
		compare_word(cfg_rdata, 32'h0000_5A00);
		$display("test register writes done");
		cfg_wr(8'h04, 4'h3, 32'h0000_0106);
		ev_pulse(6'b001101);
		compare_bit(control_status_reg_5_set, 1'b0);
		compare_bit(perr_oe, 1'b0);
		cfg_rd(8'h04, config_command_status(32'h8000_0106));
		cfg_wr(8'h04, 4'h8, 32'hFF00_0000);
		cfg_rd(8'h04, config_command_status(32'h0000_0106));
		cfg_wr(8'h04, 4'h1, 32'h0000_0046);
		ev_pulse(6'b000101);
		compare_bit(control_status_reg_5_set, 1'b1);
		compare_bit(perr_oe, 1'b1);
		cfg_rd(8'h04, config_command_status(32'h8000_0146));
		ev_pulse(6'b001101);
		cfg_rd(8'h04, config_command_status(32'h8100_0146));
		ev_pulse(6'b000010);
		compare_bit(serr_oe, 1'b1);
		compare_word({30'h0, serr_out, perr_out}, 32'h0000_0000);
		cfg_rd(8'h04, config_command_status(32'hC100_0146));
		ev_pulse(6'b111000);
		cfg_rd(8'h04, config_command_status(32'hF100_0146));
		@(posedge clk);
		cfg_write <= 1'b1;
		cfg_addr <= 8'h04;
		cfg_byte_en <= 4'h8;
		cfg_wdata <= 32'hFF00_0000;
		ev <= 6'b011000;
		@(posedge clk);
		cfg_write <= 1'b0;
		ev <= 6'h00;
		cfg_rd(8'h04, config_command_status(32'h2000_0146));
		cfg_wr(8'h04, 4'hA, 32'hFF00_0000);
		ev_pulse(6'b000010);
		compare_bit(serr_oe, 1'b0);
		cfg_rd(8'h04, config_command_status(32'h8000_0046));
		$display("test error events done");
		reset_dut();
		repeat (12) @(posedge clk);
		cfg_rd(8'h00, {DEV0 + 16'h0001, VEN0});
		cfg_rd(8'h04, config_command_status(32'h0000_0000));
		cfg_rd(8'h40, 32'h0000_0000);
		$display("test second reset done");
		finish_test();
	end
endmodule // tb_top
